// ### inc/ialu_params.svh
// named constants of the integer arithmetic and logic unit
// assumes the includer wants plain `define names, no types
`ifndef IALU_PARAMS_SVH
`define IALU_PARAMS_SVH

// flag vector bit positions and width
`define IALU_FLAG_C 0
`define IALU_FLAG_Z 1
`define IALU_FLAG_N 2
`define IALU_FLAG_V 3
`define IALU_FLAG_S 4
`define IALU_FLAG_H 5
`define IALU_FLAG_W 6

// which flags each group of operations updates
`define IALU_UPD_ARITH 6'h2F
`define IALU_UPD_WORD  6'h1F
`define IALU_UPD_LOGIC 6'h0E
`define IALU_UPD_ONES  6'h0F
`define IALU_UPD_NONE  6'h00

`define IALU_ALL_ONES  8'hFF
`define IALU_ZERO      8'h00
`define IALU_ONE       8'h01

`endif

// ### inc/ialu_pkg.sv
// types shared by the integer arithmetic and logic unit
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package ialu_pkg;
  typedef enum logic [4:0] {
    ialu_sum,
    ialu_sum_carry,
    ialu_word_immediate_sum,
    ialu_difference,
    ialu_difference_immediate,
    ialu_difference_with_borrow,
    ialu_immediate_difference_with_borrow,
    ialu_word_immediate_difference,
    ialu_conjunction,
    ialu_conjunction_immediate,
    ialu_disjunction,
    ialu_disjunction_immediate,
    ialu_exclusive_disjunction,
    ialu_ones_invert,
    ialu_twos_invert,
    ialu_bit_mask_set,
    ialu_bit_mask_clear,
    ialu_plus_one
  } ialu_op_t;

  typedef enum logic {
    ialu_st_idle,
    ialu_st_word_high
  } ialu_state_t;
endpackage
`default_nettype wire

// ### verilog/ialu_adder.sv
// adder/subtractor with carry, overflow and half-carry out
// assumes W of at least 4; purely combinational
`default_nettype none
module ialu_adder #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] a,
  input  wire logic [W-1:0] b,
  input  wire logic         cin,
  input  wire logic         sub,
  output logic      [W-1:0] r,
  output logic              c,
  output logic              v,
  output logic              h
);
  logic [W:0] wide;

  always_comb
  begin
    // in subtract mode cin is a borrow and c comes out as a borrow
    if (sub)
      wide = {1'b0, a} - {1'b0, b} - {{W{1'b0}}, cin};
    else
      wide = {1'b0, a} + {1'b0, b} + {{W{1'b0}}, cin};
    r = wide[W-1:0];
    c = wide[W];
    if (sub)
    begin
      v = (a[W-1] & ~b[W-1] & ~r[W-1]) | (~a[W-1] & b[W-1] & r[W-1]);
      h = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
    end
    else
    begin
      v = (a[W-1] & b[W-1] & ~r[W-1]) | (~a[W-1] & ~b[W-1] & r[W-1]);
      h = (a[3] & b[3]) | (b[3] & ~r[3]) | (~r[3] & a[3]);
    end
  end
endmodule
`default_nettype wire

// ### verilog/ialu_core.sv
// integer arithmetic and logic unit: operands in, write-back and flags out
// assumes the decoder holds start for one cycle and respects busy
`default_nettype none
`include "ialu_params.svh"

module ialu_core
  import ialu_pkg::*;
(
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     start,
  input  wire ialu_pkg::ialu_op_t       op,
  input  wire logic [7:0]               dst_val,
  input  wire logic [7:0]               dst_high_val,
  input  wire logic [7:0]               source_register,
  input  wire logic [7:0]               imm,
  input  wire logic                     carry_in,
  output logic                          busy,
  output logic                          wr_en,
  output logic                          wr_high,
  output logic [7:0]                    wr_data,
  output logic [`IALU_FLAG_W-1:0]       flag_we,
  output logic [`IALU_FLAG_W-1:0]       flag_val,
  output logic                          done
);
  import ialu_pkg::*;

  ialu_state_t             state;
  ialu_state_t             next_state;
  logic                    next_busy;
  logic                    next_wr_en;
  logic                    next_wr_high;
  logic [7:0]              next_wr_data;
  logic [`IALU_FLAG_W-1:0] next_flag_we;
  logic [`IALU_FLAG_W-1:0] next_flag_val;
  logic                    next_done;
  logic [7:0]              pend_high;
  logic [7:0]              next_pend_high;
  logic [`IALU_FLAG_W-1:0] pend_flags;
  logic [`IALU_FLAG_W-1:0] next_pend_flags;

  logic [7:0]  ba;
  logic [7:0]  bb;
  logic        bcin;
  logic        bsub;
  logic [7:0]  br;
  logic        bc;
  logic        bv;
  logic        bh;
  logic [15:0] wr16;
  logic        wc;
  logic        wv;
  logic        w_sub;
  logic        accept;
  logic [7:0]  res;
  logic        logic_op;

  assign accept = start && (state == ialu_st_idle);
  assign w_sub  = (op == ialu_word_immediate_difference);

  ialu_adder #(.W(8)) u_byte (
    .a   (ba),
    .b   (bb),
    .cin (bcin),
    .sub (bsub),
    .r   (br),
    .c   (bc),
    .v   (bv),
    .h   (bh)
  );

  // the word path has its own adder so both bytes settle in the first cycle
  ialu_adder #(.W(16)) u_word (
    .a   ({dst_high_val, dst_val}),
    .b   ({`IALU_ZERO, imm}),
    .cin (1'b0),
    .sub (w_sub),
    .r   (wr16),
    .c   (wc),
    .v   (wv),
    .h   ()
  );

  // operand steering for the byte adder and the logic results
  always_comb
  begin
    ba       = dst_val;
    bb       = source_register;
    bcin     = 1'b0;
    bsub     = 1'b0;
    res      = br;
    // logic group shares one flag rule, so it is decoded once here
    logic_op = op inside {ialu_conjunction, ialu_conjunction_immediate, ialu_disjunction,
                          ialu_disjunction_immediate, ialu_exclusive_disjunction,
                          ialu_bit_mask_set, ialu_bit_mask_clear};
    case (op)
      ialu_sum_carry:                        bcin = carry_in;
      ialu_difference:                       bsub = 1'b1;
      ialu_difference_immediate:
      begin
        bsub = 1'b1;
        bb   = imm;
      end
      ialu_difference_with_borrow:
      begin
        bsub = 1'b1;
        bcin = carry_in;
      end
      ialu_immediate_difference_with_borrow:
      begin
        bsub = 1'b1;
        bb   = imm;
        bcin = carry_in;
      end
      ialu_conjunction:                      res = dst_val & source_register;
      ialu_conjunction_immediate:            res = dst_val & imm;
      ialu_disjunction:                      res = dst_val | source_register;
      ialu_disjunction_immediate:            res = dst_val | imm;
      ialu_exclusive_disjunction:            res = dst_val ^ source_register;
      ialu_bit_mask_set:                     res = dst_val | imm;
      ialu_bit_mask_clear:                   res = dst_val & (`IALU_ALL_ONES - imm);
      ialu_ones_invert:
      begin
        ba   = `IALU_ALL_ONES;
        bb   = dst_val;
        bsub = 1'b1;
      end
      ialu_twos_invert:
      begin
        ba   = `IALU_ZERO;
        bb   = dst_val;
        bsub = 1'b1;
      end
      ialu_plus_one:                         bb = `IALU_ONE;
      default:                               bb = source_register;
    endcase
  end

  always_comb
  begin
    next_state      = state;
    next_busy       = 1'b0;
    next_wr_en      = 1'b0;
    next_wr_high    = 1'b0;
    next_wr_data    = wr_data;
    next_flag_we    = `IALU_UPD_NONE;
    next_flag_val   = flag_val;
    next_done       = 1'b0;
    next_pend_high  = pend_high;
    next_pend_flags = pend_flags;
    case (state)
      ialu_st_idle:
      begin
        if (accept)
        begin
          if (op == ialu_word_immediate_sum || op == ialu_word_immediate_difference)
          begin
            // low byte goes back now, high byte and flags one clock later
            next_state      = ialu_st_word_high;
            next_busy       = 1'b1;
            next_wr_en      = 1'b1;
            next_wr_data    = wr16[7:0];
            next_pend_high  = wr16[15:8];
            next_pend_flags = `IALU_UPD_NONE;
            next_pend_flags[`IALU_FLAG_C] = wc;
            next_pend_flags[`IALU_FLAG_Z] = (wr16 == {`IALU_ZERO, `IALU_ZERO});
            next_pend_flags[`IALU_FLAG_N] = wr16[15];
            next_pend_flags[`IALU_FLAG_V] = wv;
            next_pend_flags[`IALU_FLAG_S] = wr16[15] ^ wv;
          end
          else
          begin
            next_wr_en   = 1'b1;
            next_done    = 1'b1;
            next_wr_data = res;
            next_flag_val = `IALU_UPD_NONE;
            next_flag_val[`IALU_FLAG_Z] = (res == `IALU_ZERO);
            next_flag_val[`IALU_FLAG_N] = res[7];
            if (logic_op)
              next_flag_we = `IALU_UPD_LOGIC;
            else if (op == ialu_plus_one)
            begin
              next_flag_we = `IALU_UPD_LOGIC;
              next_flag_val[`IALU_FLAG_V] = bv;
            end
            else if (op == ialu_ones_invert)
            begin
              // inverting never overflows and always reports a carry
              next_flag_we = `IALU_UPD_ONES;
              next_flag_val[`IALU_FLAG_C] = 1'b1;
            end
            else
            begin
              next_flag_we = `IALU_UPD_ARITH;
              next_flag_val[`IALU_FLAG_C] = bc;
              next_flag_val[`IALU_FLAG_V] = bv;
              next_flag_val[`IALU_FLAG_H] = bh;
            end
          end
        end
      end
      ialu_st_word_high:
      begin
        next_state    = ialu_st_idle;
        next_wr_en    = 1'b1;
        next_wr_high  = 1'b1;
        next_wr_data  = pend_high;
        next_flag_we  = `IALU_UPD_WORD;
        next_flag_val = pend_flags;
        next_done     = 1'b1;
      end
      default:
        next_state = ialu_st_idle;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state      <= ialu_st_idle;
      busy       <= 1'b0;
      wr_en      <= 1'b0;
      wr_high    <= 1'b0;
      wr_data    <= `IALU_ZERO;
      flag_we    <= `IALU_UPD_NONE;
      flag_val   <= `IALU_UPD_NONE;
      done       <= 1'b0;
      pend_high  <= `IALU_ZERO;
      pend_flags <= `IALU_UPD_NONE;
    end
    else
    begin
      state      <= next_state;
      busy       <= next_busy;
      wr_en      <= next_wr_en;
      wr_high    <= next_wr_high;
      wr_data    <= next_wr_data;
      flag_we    <= next_flag_we;
      flag_val   <= next_flag_val;
      done       <= next_done;
      pend_high  <= next_pend_high;
      pend_flags <= next_pend_flags;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_sum_result: assert property (accept && op == ialu_sum_carry |=>
    wr_en && done && flag_we == `IALU_UPD_ARITH &&
    wr_data == 8'($past(dst_val) + $past(source_register) + 8'($past(carry_in))))
    else $error("sum with carry result wrong");
  a_word_sum_two: assert property (accept && op == ialu_word_immediate_sum |=>
    wr_en && !wr_high && !done && busy ##1 wr_en && wr_high && done &&
    flag_we == `IALU_UPD_WORD &&
    {wr_data, $past(wr_data)} == 16'({$past(dst_high_val, 2), $past(dst_val, 2)}
      + {8'h00, $past(imm, 2)}))
    else $error("word sum sequence wrong");
  a_diff_result: assert property (accept && op == ialu_difference |=>
    done && wr_data == 8'($past(dst_val) - $past(source_register)) &&
    flag_val[`IALU_FLAG_C] == ($past(source_register) > $past(dst_val)))
    else $error("difference result or borrow wrong");
  a_diff_imm: assert property (accept && op == ialu_difference_immediate |=>
    done && wr_data == 8'($past(dst_val) - $past(imm)) && flag_we == `IALU_UPD_ARITH)
    else $error("immediate difference wrong");
  a_borrow_diff: assert property (accept && op == ialu_difference_with_borrow |=>
    wr_data == 8'($past(dst_val) - $past(source_register) - 8'($past(carry_in))))
    else $error("borrow difference wrong");
  a_word_diff_two: assert property (accept && op == ialu_word_immediate_difference |->
    ##2 wr_high && done && {wr_data, $past(wr_data)} ==
    16'({$past(dst_high_val, 2), $past(dst_val, 2)} - {8'h00, $past(imm, 2)}))
    else $error("word difference wrong");
  a_conj_flags: assert property (accept && op == ialu_conjunction |=>
    flag_we == `IALU_UPD_LOGIC && !flag_val[`IALU_FLAG_V] &&
    wr_data == ($past(dst_val) & $past(source_register)))
    else $error("conjunction wrong");
  a_disj_imm: assert property (accept && op == ialu_disjunction_immediate |=>
    wr_data == ($past(dst_val) | $past(imm)) && flag_we == `IALU_UPD_LOGIC)
    else $error("disjunction wrong");
  a_xor_zero: assert property (accept && op == ialu_exclusive_disjunction
    && dst_val == source_register |=> flag_val[`IALU_FLAG_Z] && wr_data == 8'h00)
    else $error("exclusive disjunction zero flag wrong");
  a_mask_set: assert property (accept && op == ialu_bit_mask_set |=>
    (wr_data & $past(imm)) == $past(imm) && flag_we == `IALU_UPD_LOGIC)
    else $error("mask set wrong");
  a_mask_clear: assert property (accept && op == ialu_bit_mask_clear |=>
    (wr_data & $past(imm)) == 8'h00 && flag_we == `IALU_UPD_LOGIC)
    else $error("mask clear wrong");
  a_ones_invert: assert property (accept && op == ialu_ones_invert |=>
    wr_data == ~$past(dst_val) && flag_val[`IALU_FLAG_C] && flag_we == `IALU_UPD_ONES)
    else $error("ones invert wrong");
  a_plus_one: assert property (accept && op == ialu_plus_one |=>
    !flag_we[`IALU_FLAG_C] && wr_data == 8'($past(dst_val) + 8'h01) &&
    flag_val[`IALU_FLAG_V] == ($past(dst_val) == 8'h7F))
    else $error("plus one wrong");

  c_word_sum:  cover property (accept && op == ialu_word_immediate_sum ##2 done);
  c_borrow:    cover property (accept && op == ialu_difference_with_borrow && carry_in);
  c_twos_ovf:  cover property (accept && op == ialu_twos_invert && dst_val == 8'h80);
  c_back2back: cover property (done ##0 accept);
endmodule
`default_nettype wire

// ### testbench/ialu_regfile_model.sv
// register file stand-in: takes the core's write-back bytes and flag updates
// assumes wr_high only means something while wr_en is high
`default_nettype none
module ialu_regfile_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       wr_en,
  input  wire logic       wr_high,
  input  wire logic [7:0] wr_data,
  input  wire logic [5:0] flag_we,
  input  wire logic [5:0] flag_val,
  output logic      [7:0] lo,
  output logic      [7:0] hi,
  output logic      [5:0] fl,
  output logic      [5:0] msk,
  output logic      [3:0] nwr
);
  timeunit 1ns;
  timeprecision 100ps;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      {lo, hi, fl, msk, nwr} <= '0;
    end
    else
    begin
      if (wr_en && wr_high)
        hi <= wr_data;
      if (wr_en && !wr_high)
        lo <= wr_data;
      // counting writes exposes a missing or doubled write-back
      if (wr_en)
        nwr <= nwr + 4'h1;
      // flags outside the mask keep their old value, as in a status register
      if (flag_we != 6'h00)
        {fl, msk} <= {(fl & ~flag_we) | (flag_val & flag_we), flag_we};
    end
  end
endmodule
`default_nettype wire

// ### testbench/tb_integer_arith_logic_unit.sv
// self-checking bench of the arithmetic and logic unit
// assumes ialu_pkg and ialu_params.svh are compiled and on the include path
`default_nettype none
`include "ialu_params.svh"
module tb_integer_arith_logic_unit;
  timeunit 1ns;
  timeprecision 100ps;
  import ialu_pkg::*;

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        start = 1'b0;
  ialu_op_t    op = ialu_sum;
  logic [7:0]  dst_val = 8'h00;
  logic [7:0]  dst_high_val = 8'h00;
  logic [7:0]  source_register = 8'h00;
  logic [7:0]  imm = 8'h00;
  logic        carry_in = 1'b0;
  logic        busy, wr_en, wr_high, done;
  logic [7:0]  wr_data, lo, hi;
  logic [5:0]  flag_we, flag_val, fl, msk;
  logic [3:0]  nwr, nb;
  logic [35:0] want;
  logic [7:0]  exp_hi = 8'h00;
  int          num_errors = 0;
  int          total_checks = 0;

  always #12.5 clk = ~clk;

  ialu_core ialu_core_inst (.clk, .rst, .start, .op, .dst_val, .dst_high_val,
    .source_register, .imm, .carry_in, .busy, .wr_en, .wr_high, .wr_data, .flag_we,
    .flag_val, .done);
  ialu_regfile_model ialu_regfile_model_inst (.clk, .rst, .wr_en, .wr_high, .wr_data,
    .flag_we, .flag_val, .lo, .hi, .fl, .msk, .nwr);

  task automatic chk(input logic [35:0] s, input logic [35:0] e);
    total_checks++;
    if (s !== e)
    begin
      num_errors++;
      $display("BAD at %0t: got %h want %h", $time, s, e);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // result layout: writes, latency, high, low, flag mask, masked flags
  function automatic logic [35:0] expect_op(input ialu_op_t o, input logic [7:0] d, dh, s, k,
                                            input logic c, input logic [7:0] oh);
    logic [7:0]  a, b, r;
    logic [8:0]  t;
    logic [4:0]  hh;
    logic [16:0] w;
    logic [1:0]  kind;
    logic        ci, sub, v;
    {a, b, r, ci, sub, kind} = {d, s, 8'h00, 1'b0, 1'b0, 2'h0};
    case (o)
      ialu_sum_carry: ci = c;
      ialu_difference: sub = 1'b1;
      ialu_difference_immediate: {b, sub} = {k, 1'b1};
      ialu_difference_with_borrow: {ci, sub} = {c, 1'b1};
      ialu_immediate_difference_with_borrow: {b, ci, sub} = {k, c, 1'b1};
      ialu_twos_invert: {a, b, sub} = {8'h00, d, 1'b1};
      ialu_word_immediate_sum: kind = 2'h2;
      ialu_word_immediate_difference: {kind, sub} = {2'h2, 1'b1};
      ialu_conjunction: {kind, r} = {2'h1, d & s};
      ialu_conjunction_immediate: {kind, r} = {2'h1, d & k};
      ialu_disjunction: {kind, r} = {2'h1, d | s};
      ialu_disjunction_immediate: {kind, r} = {2'h1, d | k};
      ialu_exclusive_disjunction: {kind, r} = {2'h1, d ^ s};
      ialu_bit_mask_set: {kind, r} = {2'h1, d | k};
      ialu_bit_mask_clear: {kind, r} = {2'h1, d & (8'hFF - k)};
      ialu_ones_invert: {kind, r} = {2'h3, 8'hFF - d};
      ialu_plus_one: {kind, r} = {2'h1, d + 8'h01};
      default: kind = 2'h0;
    endcase
    t = sub ? {1'b0, a} - b - ci : {1'b0, a} + b + ci;
    hh = sub ? {1'b0, a[3:0]} - b[3:0] - ci : {1'b0, a[3:0]} + b[3:0] + ci;
    w = sub ? {1'b0, dh, d} - k : {1'b0, dh, d} + k;
    if (kind == 2'h2)
    begin
      v = sub ? (dh[7] & ~w[15]) : (~dh[7] & w[15]);
      return {8'h22, w[15:0], `IALU_UPD_WORD,
              {1'b0, w[15] ^ v, v, w[15], w[15:0] == 16'h0000, w[16]}};
    end
    if (kind == 2'h1)
      return {8'h11, oh, r, `IALU_UPD_LOGIC,
              {2'h0, o == ialu_plus_one && r == 8'h80, r[7], r == 8'h00, 1'b0}};
    if (kind == 2'h3)
      return {8'h11, oh, r, `IALU_UPD_ONES, {3'h0, r[7], r == 8'h00, 1'b1}};
    v = sub ? ((a[7] ^ b[7]) & (t[7] ^ a[7])) : (~(a[7] ^ b[7]) & (t[7] ^ a[7]));
    return {8'h11, oh, t[7:0], `IALU_UPD_ARITH, {hh[4], 1'b0, v, t[7], t[7:0] == 8'h00, t[8]}};
  endfunction

  task automatic do_op(input ialu_op_t o, input logic [7:0] d, dh, s, k, input logic c);
    logic [3:0] n0;
    int         lat;
    @(posedge clk);
    #1;
    n0 = nwr;
    lat = 1;
    op = o;
    {start, dst_val, dst_high_val, source_register, imm, carry_in} = {1'b1, d, dh, s, k, c};
    @(posedge clk);
    #1;
    // operands are only promised in the start cycle, so scramble them after it
    {start, dst_val, dst_high_val, source_register, imm, carry_in} = {1'b0, ~d, ~dh, ~s, ~k, ~c};
    while (done !== 1'b1 && lat < 4)
    begin
      @(posedge clk);
      #1;
      lat++;
    end
    @(posedge clk);
    #1;
    want = expect_op(o, d, dh, s, k, c, exp_hi);
    exp_hi = want[27:20];
    chk({nwr - n0, 4'(lat), hi, lo, msk, fl & msk}, want);
    $display("test %s finished", o.name());
  endtask

  task automatic rnd_op(input ialu_op_t o);
    repeat (12) do_op(o, 8'($urandom), 8'($urandom), 8'($urandom), 8'($urandom), 1'($urandom));
  endtask

  initial
  begin
    #(20000 * 25);
    num_errors++;
    $display("BAD at %0t: watchdog expired", $time);
    end_sim();
  end

  initial
  begin
    void'($urandom(18563));
    repeat (4) @(posedge clk);
    #1;
    rst = 1'b0;
    chk(36'({busy, wr_en, wr_high, done, wr_data, flag_we, flag_val}), 36'h0);
    do_op(ialu_sum, 8'hFF, 8'h00, 8'h01, 8'h00, 1'b1);
    do_op(ialu_sum_carry, 8'h7F, 8'h00, 8'h00, 8'h00, 1'b1);
    do_op(ialu_word_immediate_sum, 8'hFF, 8'hFF, 8'h00, 8'h01, 1'b0);
    do_op(ialu_word_immediate_sum, 8'hFF, 8'h7F, 8'h00, 8'h01, 1'b0);
    do_op(ialu_difference, 8'h80, 8'h00, 8'h01, 8'h00, 1'b0);
    do_op(ialu_difference_immediate, 8'h00, 8'h00, 8'h00, 8'h01, 1'b0);
    do_op(ialu_difference_with_borrow, 8'h00, 8'h00, 8'h00, 8'h00, 1'b1);
    do_op(ialu_immediate_difference_with_borrow, 8'h10, 8'h00, 8'h00, 8'h0F, 1'b1);
    do_op(ialu_word_immediate_difference, 8'h00, 8'h00, 8'h00, 8'h01, 1'b0);
    do_op(ialu_word_immediate_difference, 8'h00, 8'h80, 8'h00, 8'h01, 1'b0);
    do_op(ialu_bit_mask_clear, 8'hFF, 8'h00, 8'h00, 8'h0F, 1'b0);
    do_op(ialu_exclusive_disjunction, 8'h5A, 8'h00, 8'h5A, 8'h00, 1'b0);
    do_op(ialu_twos_invert, 8'h80, 8'h00, 8'h00, 8'h00, 1'b0);
    do_op(ialu_twos_invert, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0);
    do_op(ialu_ones_invert, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0);
    do_op(ialu_plus_one, 8'h7F, 8'h00, 8'h00, 8'h00, 1'b1);
    do_op(ialu_plus_one, 8'hFF, 8'h00, 8'h00, 8'h00, 1'b1);
    // back to back byte operations, start held high for two cycles
    @(posedge clk);
    #1;
    nb = nwr;
    op = ialu_sum;
    {start, dst_val, source_register} = {1'b1, 8'h11, 8'h22};
    @(posedge clk);
    #1;
    op = ialu_exclusive_disjunction;
    {dst_val, source_register} = {8'h0F, 8'hFF};
    @(posedge clk);
    #1;
    start = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk(36'({nwr - nb, lo, fl & msk}), 36'({4'h2, 8'hF0, 6'h04}));
    $display("test back_to_back finished");
    // a start during the high byte cycle of a word sum must be dropped
    @(posedge clk);
    #1;
    nb = nwr;
    op = ialu_word_immediate_sum;
    {start, dst_val, dst_high_val, imm} = {1'b1, 8'hF0, 8'h12, 8'h20};
    @(posedge clk);
    #1;
    chk(36'(busy), 36'h1);
    op = ialu_twos_invert;
    dst_val = 8'h55;
    @(posedge clk);
    #1;
    start = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    exp_hi = 8'h13;
    chk(36'({nwr - nb, hi, lo, msk}), 36'({4'h2, 8'h13, 8'h10, `IALU_UPD_WORD}));
    $display("test busy_refusal finished");
    rnd_op(ialu_sum);
    rnd_op(ialu_sum_carry);
    rnd_op(ialu_word_immediate_sum);
    rnd_op(ialu_difference);
    rnd_op(ialu_difference_immediate);
    rnd_op(ialu_difference_with_borrow);
    rnd_op(ialu_immediate_difference_with_borrow);
    rnd_op(ialu_word_immediate_difference);
    rnd_op(ialu_conjunction);
    rnd_op(ialu_conjunction_immediate);
    rnd_op(ialu_disjunction);
    rnd_op(ialu_disjunction_immediate);
    rnd_op(ialu_exclusive_disjunction);
    rnd_op(ialu_bit_mask_set);
    rnd_op(ialu_bit_mask_clear);
    rnd_op(ialu_ones_invert);
    rnd_op(ialu_twos_invert);
    rnd_op(ialu_plus_one);
    end_sim();
  end
endmodule
`default_nettype wire
